// File: rtl/mbp_block_decode.sv
// Maps a program address onto the boot block or a numbered block.
// Assumes the boot size selection is stable configuration.
`timescale 1ns/1ps
module mbp_block_decode
    import mbp_pkg::*;
#(
    parameter int MEM_KBYTES = MEM_KBYTES_DEF
)
(
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [1:0]        boot_sel,
    output logic                   in_mem,
    output logic                   in_boot,
    output logic [2:0]             blk
);

    localparam logic [ADDR_W-1:0] MEM_END = ADDR_W'(MEM_KBYTES * 1024);

    logic [ADDR_W-1:0] boot_end;

    // Boot block always starts at zero; its end follows the size field.
    always_comb
    begin
        case (boot_sel)
            BOOT_SEL_2K: boot_end = BOOT_END_2K;
            BOOT_SEL_4K: boot_end = BOOT_END_4K;
            default:     boot_end = BOOT_END_8K;
        endcase
    end

    // Numbered blocks sit on 16-Kbyte binary boundaries.
    assign in_mem  = addr < MEM_END;
    assign in_boot = in_mem && (addr < boot_end);
    assign blk     = addr[BLK_SHIFT+2:BLK_SHIFT];

endmodule

// File: rtl/mbp_checker.sv
// Access checker guarding program memory, data EEPROM and protection bytes.
// Assumes CPU and programming port requests arrive on sys_clk, one cycle each.
// Operation
// - Program memory splits into boot block plus numbered blocks by variant size.
// - Boot block starts at zero, 2, 4 or 8 Kbytes by boot size field.
// - Other blocks lie on 16-Kbyte binary boundaries; block 0 fills the rest below 004000h.
// - Every block owns programmer, write and foreign-read protection bits.
// - Programmer locks sit at 300008h, EEPROM and boot locks at 300009h.
// - Write locks at 30000Ah; EEPROM, boot, config write locks at 30000Bh.
// - Foreign-read guards at 30000Ch; boot guard is bit 6 of 30000Dh.
// - Programmer locks only stop programming port access, never CPU access.
// - Table write into a block whose write lock is zero is rejected.
// - Guarded block reads succeed only from code inside it, else zeros.
// - Protection bits can only be cleared, never set by a write.
// - Only chip or block erase sets protection bits; CPU cannot erase.
// - Erases come only from the external programmer port.
// - Table reads reach memory, device ID and config; writes reach memory and config.
// - EEPROM programmer lock blocks programmer reads and writes of EEPROM.
// - EEPROM write lock blocks CPU and programmer EEPROM writes.
// - CPU reads of data EEPROM are always allowed.
// - Config write lock is read-only to the CPU, changed by programmer.
`timescale 1ns/1ps
module mbp_checker
    import mbp_pkg::*;
#(
    parameter int MEM_KBYTES = MEM_KBYTES_DEF
)
(
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic [1:0]   boot_size_select,
    input  wire mbp_cpu_req_s cpu_req,
    input  wire logic [7:0]   cpu_mem_rdata,
    output mbp_cpu_rsp_s      cpu_rsp,
    input  wire mbp_pgm_req_s pgm_req,
    input  wire logic [7:0]   pgm_mem_rdata,
    output mbp_pgm_rsp_s      pgm_rsp,
    input  wire mbp_ee_req_s  ee_req,
    output mbp_ee_rsp_s       ee_rsp
);

    // Only the four documented memory sizes are served.
    generate
        if (MEM_KBYTES != 48 && MEM_KBYTES != 64 && MEM_KBYTES != 96 && MEM_KBYTES != 128)
        begin : g_bad_size
            $error("MEM_KBYTES must be 48, 64, 96 or 128.");
        end
    endgenerate

    mbp_state_s st_r;
    mbp_state_s st_nxt;

    logic       ptr_in_mem;
    logic       ptr_boot;
    logic [2:0] ptr_blk;
    logic       pc_in_mem;
    logic       pc_boot;
    logic [2:0] pc_blk;
    logic       pa_in_mem;
    logic       pa_boot;
    logic [2:0] pa_blk;

    logic       cpu_cfg_hit;
    logic [2:0] cpu_cfg_idx;
    logic       cpu_id_hit;
    logic       cpu_wr_lock;
    logic       cpu_guard;
    logic       same_blk;
    logic       cpu_rd_ok;
    logic       cpu_wr_ok;
    logic [7:0] cpu_rd_data;

    logic       pgm_cfg_hit;
    logic [2:0] pgm_cfg_idx;
    logic       pgm_id_hit;
    logic       pgm_blk_lock;
    logic       pgm_erase;
    logic       pgm_ok;
    logic [7:0] pgm_rd_data;
    logic       ee_ok;

    // Address decoders for the table pointer, the reading code and the port.
    mbp_block_decode #(.MEM_KBYTES(MEM_KBYTES)) u_ptr_dec
    (
        .addr     (cpu_req.ptr),
        .boot_sel (boot_size_select),
        .in_mem   (ptr_in_mem),
        .in_boot  (ptr_boot),
        .blk      (ptr_blk)
    );

    mbp_block_decode #(.MEM_KBYTES(MEM_KBYTES)) u_pc_dec
    (
        .addr     (cpu_req.pc),
        .boot_sel (boot_size_select),
        .in_mem   (pc_in_mem),
        .in_boot  (pc_boot),
        .blk      (pc_blk)
    );

    mbp_block_decode #(.MEM_KBYTES(MEM_KBYTES)) u_pgm_dec
    (
        .addr     (pgm_req.addr),
        .boot_sel (boot_size_select),
        .in_mem   (pa_in_mem),
        .in_boot  (pa_boot),
        .blk      (pa_blk)
    );

    // Protection byte and device ID hits for both requesters.
    assign cpu_cfg_hit = (cpu_req.ptr >= CFG_BLK_PGM_ADDR) && (cpu_req.ptr <= CFG_SPC_GRD_ADDR);
    assign cpu_cfg_idx = 3'(cpu_req.ptr - CFG_BLK_PGM_ADDR);
    assign cpu_id_hit  = (cpu_req.ptr == DEVID_LO_ADDR) || (cpu_req.ptr == DEVID_HI_ADDR);
    assign pgm_cfg_hit = (pgm_req.addr >= CFG_BLK_PGM_ADDR) && (pgm_req.addr <= CFG_SPC_GRD_ADDR);
    assign pgm_cfg_idx = 3'(pgm_req.addr - CFG_BLK_PGM_ADDR);
    assign pgm_id_hit  = (pgm_req.addr == DEVID_LO_ADDR) || (pgm_req.addr == DEVID_HI_ADDR);

    // Per-block bits selected by the target block of the table pointer.
    assign cpu_wr_lock = ptr_boot ? st_r.cfg[IDX_SPC_WR][BIT_BOOT]
                                  : st_r.cfg[IDX_BLK_WR][ptr_blk];
    assign cpu_guard   = ptr_boot ? st_r.cfg[IDX_SPC_GRD][BIT_BOOT]
                                  : st_r.cfg[IDX_BLK_GRD][ptr_blk];
    assign same_blk    = pc_in_mem && (pc_boot == ptr_boot) && (ptr_boot || pc_blk == ptr_blk);

    // Table read permission and the byte returned in the table latch.
    always_comb
    begin
        cpu_rd_ok   = 1'b0;
        cpu_rd_data = 8'h00;
        if (cpu_cfg_hit)
        begin
            cpu_rd_ok   = 1'b1;
            cpu_rd_data = st_r.cfg[cpu_cfg_idx] & CFG_IMPL_MASK[cpu_cfg_idx];
        end
        else if (cpu_id_hit)
        begin
            cpu_rd_ok   = 1'b1;
            cpu_rd_data = cpu_mem_rdata;
        end
        else if (ptr_in_mem && (cpu_guard || same_blk))
        begin
            cpu_rd_ok   = 1'b1;
            cpu_rd_data = cpu_mem_rdata;
        end
    end

    // Table write permission; programmer locks play no part here.
    always_comb
    begin
        if (ptr_in_mem)
        begin
            cpu_wr_ok = cpu_wr_lock;
        end
        else if (cpu_cfg_hit)
        begin
            cpu_wr_ok = st_r.cfg[IDX_SPC_WR][BIT_CONFIG];
        end
        else
        begin
            cpu_wr_ok = 1'b0;
        end
    end

    // Programming port permission for memory, EEPROM and protection bytes.
    assign pgm_blk_lock = pa_boot ? st_r.cfg[IDX_SPC_PGM][BIT_BOOT]
                                  : st_r.cfg[IDX_BLK_PGM][pa_blk];
    assign pgm_erase    = pgm_req.chip_erase || pgm_req.block_erase;

    always_comb
    begin
        pgm_ok      = 1'b0;
        pgm_rd_data = 8'h00;
        if (pgm_erase)
        begin
            pgm_ok = 1'b1;
        end
        else if (pgm_req.eeprom)
        begin
            pgm_ok = st_r.cfg[IDX_SPC_PGM][BIT_EEPROM]
                  && (!pgm_req.write || st_r.cfg[IDX_SPC_WR][BIT_EEPROM]);
            pgm_rd_data = pgm_mem_rdata;
        end
        else if (pgm_cfg_hit)
        begin
            pgm_ok      = 1'b1;
            pgm_rd_data = st_r.cfg[pgm_cfg_idx] & CFG_IMPL_MASK[pgm_cfg_idx];
        end
        else if (pgm_id_hit)
        begin
            pgm_ok      = !pgm_req.write;
            pgm_rd_data = pgm_mem_rdata;
        end
        else if (pa_in_mem)
        begin
            pgm_ok      = pgm_blk_lock;
            pgm_rd_data = pgm_mem_rdata;
        end
        if (!pgm_ok)
        begin
            pgm_rd_data = 8'h00;
        end
    end

    // CPU EEPROM reads always pass; writes obey the EEPROM write lock.
    assign ee_ok = !ee_req.write || st_r.cfg[IDX_SPC_WR][BIT_EEPROM];

    // Next state: answers, then protection byte updates with erase last.
    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.cpu.done  = cpu_req.valid;
        st_nxt.cpu.wr_en = cpu_req.valid && cpu_req.write && cpu_wr_ok && ptr_in_mem;
        st_nxt.cpu.rd_ok = cpu_req.valid && !cpu_req.write && cpu_rd_ok;
        if (cpu_req.valid && !cpu_req.write)
        begin
            st_nxt.cpu.latch = cpu_rd_data;
        end
        st_nxt.pgm.done = pgm_req.valid;
        st_nxt.pgm.ok   = pgm_req.valid && pgm_ok;
        if (pgm_req.valid && !pgm_req.write && !pgm_erase)
        begin
            st_nxt.pgm.rdata = pgm_rd_data;
        end
        st_nxt.ee.done = ee_req.valid;
        st_nxt.ee.ok   = ee_req.valid && ee_ok;
        // CPU writes may only clear bits and never touch the config write lock.
        if (cpu_req.valid && cpu_req.write && cpu_cfg_hit && cpu_wr_ok)
        begin
            st_nxt.cfg[cpu_cfg_idx] = st_r.cfg[cpu_cfg_idx]
                                    & (cpu_req.wdata | ~CFG_CPU_MASK[cpu_cfg_idx]);
        end
        // Programmer writes may also only clear bits.
        if (pgm_req.valid && pgm_req.write && !pgm_req.eeprom && !pgm_erase && pgm_cfg_hit)
        begin
            st_nxt.cfg[pgm_cfg_idx] = st_nxt.cfg[pgm_cfg_idx]
                                    & (pgm_req.wdata | ~CFG_IMPL_MASK[pgm_cfg_idx]);
        end
        // Erase from the programming port is the only way back to one.
        if (pgm_req.valid && pgm_req.chip_erase)
        begin
            st_nxt.cfg = {CFG_NUM{CFG_RESET}};
        end
        else if (pgm_req.valid && pgm_req.block_erase)
        begin
            if (pgm_req.erase_id == ERASE_ID_BOOT)
            begin
                st_nxt.cfg[IDX_SPC_PGM][BIT_BOOT] = 1'b1;
                st_nxt.cfg[IDX_SPC_WR][BIT_BOOT]  = 1'b1;
                st_nxt.cfg[IDX_SPC_GRD][BIT_BOOT] = 1'b1;
            end
            else if (pgm_req.erase_id == ERASE_ID_EEPROM)
            begin
                st_nxt.cfg[IDX_SPC_PGM][BIT_EEPROM] = 1'b1;
                st_nxt.cfg[IDX_SPC_WR][BIT_EEPROM]  = 1'b1;
            end
            else if (!pgm_req.erase_id[3])
            begin
                st_nxt.cfg[IDX_BLK_PGM][pgm_req.erase_id[2:0]] = 1'b1;
                st_nxt.cfg[IDX_BLK_WR][pgm_req.erase_id[2:0]]  = 1'b1;
                st_nxt.cfg[IDX_BLK_GRD][pgm_req.erase_id[2:0]] = 1'b1;
            end
        end
    end

    // State register; reset leaves every protection bit erased.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_r     <= '0;
            st_r.cfg <= {CFG_NUM{CFG_RESET}};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign cpu_rsp = st_r.cpu;
    assign pgm_rsp = st_r.pgm;
    assign ee_rsp  = st_r.ee;

    // A locked table write finishes next cycle without a memory write.
    AST_WR_LOCK_REJECT: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cpu_req.valid && cpu_req.write && ptr_in_mem && !cpu_wr_lock)
        |=> (cpu_rsp.done && !cpu_rsp.wr_en))
        else $error("Locked table write was not rejected.");

    // Programmer lock alone never stops a CPU table write.
    AST_PGM_LOCK_CPU_FREE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cpu_req.valid && cpu_req.write && ptr_in_mem && !ptr_boot
         && cpu_wr_lock && !st_r.cfg[IDX_BLK_PGM][ptr_blk])
        |=> cpu_rsp.wr_en)
        else $error("Programmer lock stopped a CPU table write.");

    // Foreign read of a guarded block returns zeros.
    AST_FOREIGN_READ_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cpu_req.valid && !cpu_req.write && ptr_in_mem && !cpu_guard && !same_blk)
        |=> (cpu_rsp.latch == 8'h00 && !cpu_rsp.rd_ok))
        else $error("Foreign read of a guarded block returned data.");

    // Protection bits never rise without an erase.
    AST_CLEAR_ONLY: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !(pgm_req.valid && pgm_erase)
        |=> ((~$past(st_r.cfg)) & st_r.cfg) == '0)
        else $error("Protection bit rose without an erase.");

    // Chip erase returns every protection byte to the erased value.
    AST_CHIP_ERASE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pgm_req.valid && pgm_req.chip_erase)
        |=> (st_r.cfg == {CFG_NUM{CFG_RESET}} && pgm_rsp.done && pgm_rsp.ok))
        else $error("Chip erase did not restore the protection bytes.");

    // Locked EEPROM refuses programmer access.
    AST_EE_PGM_LOCK: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pgm_req.valid && pgm_req.eeprom && !pgm_erase && !st_r.cfg[IDX_SPC_PGM][BIT_EEPROM])
        |=> (pgm_rsp.done && !pgm_rsp.ok && (pgm_rsp.rdata == 8'h00 || $past(pgm_req.write))))
        else $error("Locked EEPROM answered the programmer.");

    // EEPROM write lock refuses CPU writes.
    AST_EE_WR_LOCK: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ee_req.valid && ee_req.write && !st_r.cfg[IDX_SPC_WR][BIT_EEPROM])
        |=> (ee_rsp.done && !ee_rsp.ok))
        else $error("EEPROM write passed the write lock.");

    // CPU EEPROM reads always pass.
    AST_EE_READ_FREE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ee_req.valid && !ee_req.write) |=> (ee_rsp.done && ee_rsp.ok))
        else $error("CPU EEPROM read was refused.");

    // CPU writes never change the config write lock.
    AST_CFG_LOCK_RO: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cpu_req.valid && cpu_req.write && !(pgm_req.valid && (pgm_req.write || pgm_erase)))
        |=> st_r.cfg[IDX_SPC_WR][BIT_CONFIG] == $past(st_r.cfg[IDX_SPC_WR][BIT_CONFIG]))
        else $error("CPU changed the config write lock.");

    // A rejected table write finishes exactly one cycle later as a pulse.
    AST_NO_STALL: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cpu_req.valid && cpu_req.write && !cpu_wr_ok) ##1 !cpu_req.valid
        |-> (cpu_rsp.done && !cpu_rsp.wr_en) ##1 !cpu_rsp.done)
        else $error("Table access did not finish in one cycle.");

endmodule

// File: rtl/mbp_pkg.sv
// Shared constants and carrier types of the program memory protection checker.
// Assumes every user of it runs on the single system clock.
package mbp_pkg;

    // Address width of the table pointer and of the programming port.
    localparam int ADDR_W = 22;

    // Default program memory size in Kbytes and the span of one block.
    localparam int MEM_KBYTES_DEF = 128;
    localparam int BLK_SHIFT      = 14;

    // Ends (exclusive) of the boot block for each boot size selection.
    localparam logic [21:0] BOOT_END_2K = 22'h000800;
    localparam logic [21:0] BOOT_END_4K = 22'h001000;
    localparam logic [21:0] BOOT_END_8K = 22'h002000;
    localparam logic [1:0]  BOOT_SEL_2K = 2'h0;
    localparam logic [1:0]  BOOT_SEL_4K = 2'h1;

    // Byte addresses of the protection configuration bytes.
    localparam logic [21:0] CFG_BLK_PGM_ADDR = 22'h300008;
    localparam logic [21:0] CFG_SPC_PGM_ADDR = 22'h300009;
    localparam logic [21:0] CFG_BLK_WR_ADDR  = 22'h30000A;
    localparam logic [21:0] CFG_SPC_WR_ADDR  = 22'h30000B;
    localparam logic [21:0] CFG_BLK_GRD_ADDR = 22'h30000C;
    localparam logic [21:0] CFG_SPC_GRD_ADDR = 22'h30000D;

    // Device identification word, readable by table reads and programmer reads, never written.
    localparam logic [21:0] DEVID_LO_ADDR = 22'h3FFFFE;
    localparam logic [21:0] DEVID_HI_ADDR = 22'h3FFFFF;

    // Indices of the configuration bytes inside the state array.
    localparam logic [2:0] IDX_BLK_PGM = 3'h0;
    localparam logic [2:0] IDX_SPC_PGM = 3'h1;
    localparam logic [2:0] IDX_BLK_WR  = 3'h2;
    localparam logic [2:0] IDX_SPC_WR  = 3'h3;
    localparam logic [2:0] IDX_BLK_GRD = 3'h4;
    localparam logic [2:0] IDX_SPC_GRD = 3'h5;
    localparam int         CFG_NUM     = 6;

    // Bit positions inside the special bytes.
    localparam int BIT_EEPROM = 7;
    localparam int BIT_BOOT   = 6;
    localparam int BIT_CONFIG = 5;

    // Erased value of a configuration byte.
    localparam logic [7:0] CFG_RESET = 8'hFF;

    // Implemented bits per byte, and bits that CPU table writes may clear.
    localparam logic [5:0][7:0] CFG_IMPL_MASK = {8'h40, 8'hFF, 8'hE0, 8'hFF, 8'hC0, 8'hFF};
    localparam logic [5:0][7:0] CFG_CPU_MASK  = {8'h40, 8'hFF, 8'hC0, 8'hFF, 8'hC0, 8'hFF};

    // Block erase targets beyond the numbered blocks.
    localparam logic [3:0] ERASE_ID_BOOT   = 4'h8;
    localparam logic [3:0] ERASE_ID_EEPROM = 4'h9;

    // Table access request from the CPU.
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] ptr;
        logic [ADDR_W-1:0] pc;
        logic [7:0]        wdata;
    } mbp_cpu_req_s;

    // Table access answer to the CPU.
    typedef struct packed {
        logic       done;
        logic       wr_en;
        logic       rd_ok;
        logic [7:0] latch;
    } mbp_cpu_rsp_s;

    // Request from the external programming port.
    typedef struct packed {
        logic              valid;
        logic              write;
        logic              eeprom;
        logic              chip_erase;
        logic              block_erase;
        logic [3:0]        erase_id;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } mbp_pgm_req_s;

    // Answer to the external programming port.
    typedef struct packed {
        logic       done;
        logic       ok;
        logic [7:0] rdata;
    } mbp_pgm_rsp_s;

    // CPU data EEPROM access and its answer.
    typedef struct packed {
        logic valid;
        logic write;
    } mbp_ee_req_s;

    typedef struct packed {
        logic done;
        logic ok;
    } mbp_ee_rsp_s;

    // Whole state of the checker.
    typedef struct packed {
        logic [5:0][7:0] cfg;
        mbp_cpu_rsp_s    cpu;
        mbp_pgm_rsp_s    pgm;
        mbp_ee_rsp_s     ee;
    } mbp_state_s;

endpackage

// File: testbench/mbp_mem_model.sv
// Memory model standing behind the checker: program memory, data EEPROM and device ID bytes.
// Assumes requests are one-cycle pulses on sys_clk; the byte is a fixed pattern of the address.
`timescale 1ns/1ps
module mbp_mem_model
    import mbp_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire mbp_cpu_req_s cpu_req,
    input  wire mbp_pgm_req_s pgm_req,
    output logic [7:0]        cpu_mem_rdata,
    output logic [7:0]        pgm_mem_rdata
);
    logic [7:0] cpu_last;
    logic [7:0] pgm_last;

    // Byte stored at an address; the bench derives its expectations the same way.
    function automatic logic [7:0] pattern(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction

    // Outside a request the read bus shows the inverse of its last value, so stale data never matches.
    always_comb
    begin
        cpu_mem_rdata = cpu_req.valid ? pattern(cpu_req.ptr) : ~cpu_last;
        pgm_mem_rdata = pgm_req.valid ? pattern(pgm_req.addr) : ~pgm_last;
    end

    // Remembers the last byte handed out on each port.
    always @(posedge sys_clk)
    begin
        cpu_last <= cpu_mem_rdata;
        pgm_last <= pgm_mem_rdata;
    end
endmodule

// File: testbench/tb_memory_block_protection.sv
// Self-checking bench of the protection checker, driving CPU, programmer and EEPROM ports.
// Assumes a 128-Kbyte part and the one-cycle answer of every port.
`timescale 1ns/1ps
module tb_memory_block_protection;
    import mbp_pkg::*;
    logic         sys_clk;
    logic         sys_rst;
    logic [1:0]   boot_size_select;
    mbp_cpu_req_s cpu_req;
    logic [7:0]   cpu_mem_rdata;
    mbp_cpu_rsp_s cpu_rsp;
    mbp_pgm_req_s pgm_req;
    logic [7:0]   pgm_mem_rdata;
    mbp_pgm_rsp_s pgm_rsp;
    mbp_ee_req_s  ee_req;
    mbp_ee_rsp_s  ee_rsp;
    int           n_errors;
    int           check_count;
    int           cycles;

    mbp_checker #(.MEM_KBYTES(128)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .boot_size_select(boot_size_select), .cpu_req(cpu_req), .cpu_mem_rdata(cpu_mem_rdata),
        .cpu_rsp(cpu_rsp), .pgm_req(pgm_req), .pgm_mem_rdata(pgm_mem_rdata), .pgm_rsp(pgm_rsp),
        .ee_req(ee_req), .ee_rsp(ee_rsp));
    mbp_mem_model mem_u (.sys_clk(sys_clk), .cpu_req(cpu_req), .pgm_req(pgm_req),
        .cpu_mem_rdata(cpu_mem_rdata), .pgm_mem_rdata(pgm_mem_rdata));

    // Clock of 5 ns.
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Cuts a hang short well beyond the length of the sequence.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            conclude();
        end
    end

    // Expected memory byte at an address.
    function automatic logic [7:0] mb(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction

    // Compares one byte or flag group and counts the result.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One CPU table access; ok is the expected memory write enable or read permission.
    task automatic cpu_op(input logic wr, input logic [21:0] ptr, input logic [21:0] pc,
                          input logic [7:0] wd, input logic ok, input logic [7:0] lat);
        @(posedge sys_clk);
        cpu_req <= '{1'b1, wr, ptr, pc, wd};
        @(posedge sys_clk);
        cpu_req.valid <= 1'b0;
        #1;
        check({5'h00, cpu_rsp.done, cpu_rsp.wr_en, cpu_rsp.rd_ok}, {5'h00, 1'b1, wr & ok, ~wr & ok});
        if (!wr)
            check(cpu_rsp.latch, lat);
    endtask

    // One programmer read or write of memory, EEPROM or a protection byte.
    task automatic pgm_op(input logic wr, input logic ee, input logic [21:0] addr,
                          input logic [7:0] wd, input logic ok, input logic [7:0] rd);
        @(posedge sys_clk);
        pgm_req <= '{1'b1, wr, ee, 1'b0, 1'b0, 4'h0, addr, wd};
        @(posedge sys_clk);
        pgm_req.valid <= 1'b0;
        #1;
        check({6'h00, pgm_rsp.done, pgm_rsp.ok}, {6'h00, 1'b1, ok});
        if (!wr)
            check(pgm_rsp.rdata, rd);
    endtask

    // Chip erase, or block erase of one target, from the programmer.
    task automatic erase(input logic chip, input logic [3:0] id);
        @(posedge sys_clk);
        pgm_req <= '{1'b1, 1'b0, 1'b0, chip, ~chip, id, 22'h000000, 8'h00};
        @(posedge sys_clk);
        pgm_req.valid <= 1'b0;
        #1;
        check({6'h00, pgm_rsp.done, pgm_rsp.ok}, 8'h03);
    endtask

    // One CPU data EEPROM access.
    task automatic ee_op(input logic wr, input logic ok);
        @(posedge sys_clk);
        ee_req <= '{1'b1, wr};
        @(posedge sys_clk);
        ee_req.valid <= 1'b0;
        #1;
        check({6'h00, ee_rsp.done, ee_rsp.ok}, {6'h00, 1'b1, ok});
    endtask

    // Reads all six protection bytes through the programmer.
    task automatic cfg_all(input logic [5:0][7:0] e);
        for (int i = 0; i < 6; i++)
            pgm_op(1'b0, 1'b0, CFG_BLK_PGM_ADDR + 22'(i), 8'h00, 1'b1, e[i]);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        sys_rst = 1'b1;
        boot_size_select = 2'h0;
        cpu_req = '0;
        pgm_req = '0;
        ee_req = '0;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        cfg_all({8'h40, 8'hFF, 8'hE0, 8'hFF, 8'hC0, 8'hFF});
        cpu_op(0, 22'h004123, 22'h000100, 8'h00, 1, mb(22'h004123));
        cpu_op(0, 22'h30000B, 22'h000100, 8'h00, 1, 8'hE0);
        cpu_op(1, 22'h004123, 22'h000100, 8'h12, 1, 8'h00);
        cpu_op(0, 22'h3FFFFE, 22'h000100, 8'h00, 1, mb(22'h3FFFFE));
        cpu_op(1, 22'h3FFFFE, 22'h000100, 8'h00, 0, 8'h00);
        cpu_op(0, 22'h020000, 22'h000100, 8'h00, 0, 8'h00);
        // Write locks: block 1 by the programmer, boot by the CPU.
        pgm_op(1, 0, 22'h30000A, 8'hFD, 1, 8'h00);
        cpu_op(1, 22'h004123, 22'h000100, 8'h12, 0, 8'h00);
        cpu_op(1, 22'h008000, 22'h000100, 8'h12, 1, 8'h00);
        cpu_op(1, 22'h30000B, 22'h000100, 8'hBF, 0, 8'h00);
        cpu_op(1, 22'h30000A, 22'h000100, 8'hFF, 0, 8'h00);
        pgm_op(0, 0, 22'h30000A, 8'h00, 1, 8'hFD);
        cpu_op(1, 22'h000900, 22'h000100, 8'h12, 1, 8'h00);
        @(posedge sys_clk) boot_size_select <= 2'h1;
        cpu_op(1, 22'h000900, 22'h000100, 8'h12, 0, 8'h00);
        cpu_op(1, 22'h001F00, 22'h000100, 8'h12, 1, 8'h00);
        @(posedge sys_clk) boot_size_select <= 2'h2;
        cpu_op(1, 22'h001F00, 22'h000100, 8'h12, 0, 8'h00);
        @(posedge sys_clk) boot_size_select <= 2'h1;
        // Foreign read guards of block 0 and the boot block.
        pgm_op(1, 0, 22'h30000C, 8'hFE, 1, 8'h00);
        cpu_op(0, 22'h002000, 22'h007FFE, 8'h00, 0, 8'h00);
        cpu_op(0, 22'h002000, 22'h003000, 8'h00, 1, mb(22'h002000));
        cpu_op(0, 22'h000900, 22'h007FFE, 8'h00, 1, mb(22'h000900));
        cpu_op(1, 22'h30000D, 22'h000100, 8'hBF, 0, 8'h00);
        cpu_op(0, 22'h000900, 22'h007FFE, 8'h00, 0, 8'h00);
        cpu_op(0, 22'h000900, 22'h000F00, 8'h00, 1, mb(22'h000900));
        // Programmer locks stop only the programming port.
        pgm_op(1, 0, 22'h300008, 8'hFB, 1, 8'h00);
        pgm_op(0, 0, 22'h008000, 8'h00, 0, 8'h00);
        pgm_op(0, 0, 22'h004000, 8'h00, 1, mb(22'h004000));
        cpu_op(0, 22'h008000, 22'h000100, 8'h00, 1, mb(22'h008000));
        cpu_op(1, 22'h008000, 22'h000100, 8'h12, 1, 8'h00);
        cpu_op(1, 22'h300009, 22'h000100, 8'hBF, 0, 8'h00);
        pgm_op(0, 0, 22'h000100, 8'h00, 0, 8'h00);
        // Data EEPROM locks.
        ee_op(1, 1);
        pgm_op(1, 1, 22'h000010, 8'h55, 1, 8'h00);
        cpu_op(1, 22'h30000B, 22'h000100, 8'h7F, 0, 8'h00);
        ee_op(1, 0);
        ee_op(0, 1);
        pgm_op(1, 1, 22'h000010, 8'h55, 0, 8'h00);
        pgm_op(0, 1, 22'h000010, 8'h00, 1, mb(22'h000010));
        pgm_op(1, 0, 22'h300009, 8'h7F, 1, 8'h00);
        pgm_op(0, 1, 22'h000010, 8'h00, 0, 8'h00);
        ee_op(0, 1);
        // Configuration write lock is changed only by the programmer.
        cpu_op(1, 22'h30000B, 22'h000100, 8'h00, 0, 8'h00);
        pgm_op(0, 0, 22'h30000B, 8'h00, 1, 8'h20);
        pgm_op(1, 0, 22'h30000B, 8'hDF, 1, 8'h00);
        cpu_op(1, 22'h30000A, 22'h000100, 8'h00, 0, 8'h00);
        // Erases from the programmer restore protection bits.
        erase(1'b0, 4'h1);
        cfg_all({8'h00, 8'hFE, 8'h00, 8'hFF, 8'h00, 8'hFB});
        erase(1'b1, 4'h0);
        cfg_all({8'h40, 8'hFF, 8'hE0, 8'hFF, 8'hC0, 8'hFF});
        cpu_op(1, 22'h004123, 22'h000100, 8'h12, 1, 8'h00);
        conclude();
    end
endmodule
